// File: hdl/itr_pkg.sv
// itr_pkg: shared constants and types for the interval timer count readback.
// assumes: one 25 MHz clock mclk on both ends; 8-bit peripheral bus in between.
package itr_pkg;
	localparam int NUM_CNT = 3;
	// port select values; counter_snapshot_command sits at port 0x3
	localparam logic [1:0] PORT_CTRL = 2'h3;
	// control word fields
	localparam int CW_SEL_HI = 7;
	localparam int CW_SEL_LO = 6;
	localparam int CW_ACC_HI = 5;
	localparam int CW_ACC_LO = 4;
	localparam int CW_BCD = 0;
	typedef enum logic [1:0] {
		ACC_LATCH = 2'b00,
		ACC_LOW = 2'b01,
		ACC_HIGH = 2'b10,
		ACC_BOTH = 2'b11
	} itr_access_type;
	localparam logic [1:0] ACC_RESET = 2'h3;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BUS_IDLE = 8'hff;
	localparam logic [3:0] BCD_NINE = 4'h9;
	// bus timing, ns and derived mclk cycles (least times round up)
	localparam int MCLK_NS = 40;
	localparam int ADDR_SETUP_NS = 45;
	localparam int STROBE_NS = 150;
	localparam int RECOVERY_NS = 200;
	localparam logic [2:0] ADDR_SETUP_CYC = 3'((ADDR_SETUP_NS + MCLK_NS - 1) / MCLK_NS);
	localparam logic [2:0] STROBE_CYC = 3'((STROBE_NS + MCLK_NS - 1) / MCLK_NS);
	localparam logic [2:0] RECOVERY_CYC = 3'((RECOVERY_NS + MCLK_NS - 1) / MCLK_NS);
	// host apb registers
	localparam int APB_ADDR_W = 12;
	localparam logic [11:0] REG_CMD = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_HOLD = 12'h008;
	localparam int CMD_WRITE = 0;
	localparam int CMD_PORT_LO = 1;
	localparam int CMD_DATA_LO = 8;
	localparam int ST_BUSY = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_DONE = 2;
	localparam int ST_DATA_LO = 8;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_SETUP = 2'b01,
		HS_STROBE = 2'b10,
		HS_RECOVER = 2'b11
	} itr_host_state_type;
endpackage : itr_pkg

// File: hdl/itr_bus_if.sv
// itr_bus_if: the 8-bit peripheral bus between host and timer.
// assumes: both ends clocked by mclk; data resolved here from the two enables.
`timescale 1ns/100ps
interface itr_bus_if import itr_pkg::*;;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic port_select_high;
	logic port_select_low;
	logic [7:0] host_data_out;
	logic host_data_oe_n;
	logic [7:0] dev_data_out;
	logic dev_data_oe_n;
	logic [7:0] data;
	// undriven bus reads as pulled up
	assign data = !host_data_oe_n ? host_data_out :
		(!dev_data_oe_n ? dev_data_out : BUS_IDLE);
	modport host (
		output cs_n, rd_n, wr_n, port_select_high, port_select_low,
		output host_data_out, host_data_oe_n,
		input data
	);
	modport dev (
		input cs_n, rd_n, wr_n, port_select_high, port_select_low,
		input data,
		output dev_data_out, dev_data_oe_n
	);
endinterface : itr_bus_if

// File: hdl/itr_bus_seq.sv
// itr_bus_seq: host side bus cycle sequencer, one read or write per start.
// assumes: caller issues start only while busy is low.
`timescale 1ns/100ps
module itr_bus_seq import itr_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// request
	input wire logic start,
	input wire logic is_write,
	input wire logic [1:0] port,
	input wire logic [7:0] wdata,
	// answer
	output logic busy,
	output logic done,
	output logic [7:0] rdata,
	// bus
	itr_bus_if.host bus
);
	itr_host_state_type state_reg;
	logic [2:0] timer_reg;
	logic write_reg;

	assign busy = state_reg != HS_IDLE;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= HS_IDLE;
			timer_reg <= '0;
			write_reg <= 1'b0;
			done <= 1'b0;
			rdata <= BYTE_ZERO;
			bus.cs_n <= 1'b1;
			bus.rd_n <= 1'b1;
			bus.wr_n <= 1'b1;
			bus.port_select_high <= 1'b0;
			bus.port_select_low <= 1'b0;
			bus.host_data_out <= BYTE_ZERO;
			bus.host_data_oe_n <= 1'b1;
		end else begin
			done <= 1'b0;
			case (state_reg)
				HS_IDLE: begin
					if (start) begin
						{bus.port_select_high, bus.port_select_low} <= port;
						bus.cs_n <= 1'b0;
						// write data goes out with the address, well before the strobe
						bus.host_data_out <= wdata;
						bus.host_data_oe_n <= !is_write;
						write_reg <= is_write;
						timer_reg <= ADDR_SETUP_CYC - 3'h1;
						state_reg <= HS_SETUP;
					end
				end
				HS_SETUP: begin
					if (timer_reg == '0) begin
						bus.rd_n <= write_reg;
						bus.wr_n <= !write_reg;
						timer_reg <= STROBE_CYC - 3'h1;
						state_reg <= HS_STROBE;
					end else begin
						timer_reg <= timer_reg - 3'h1;
					end
				end
				HS_STROBE: begin
					if (timer_reg == '0) begin
						if (!write_reg) begin
							rdata <= bus.data;
						end
						bus.rd_n <= 1'b1;
						bus.wr_n <= 1'b1;
						bus.cs_n <= 1'b1;
						bus.host_data_oe_n <= 1'b1;
						timer_reg <= RECOVERY_CYC - 3'h1;
						state_reg <= HS_RECOVER;
					end else begin
						timer_reg <= timer_reg - 3'h1;
					end
				end
				HS_RECOVER: begin
					if (timer_reg == '0) begin
						done <= 1'b1;
						state_reg <= HS_IDLE;
					end else begin
						timer_reg <= timer_reg - 3'h1;
					end
				end
				default: state_reg <= HS_IDLE;
			endcase
		end
	end
endmodule : itr_bus_seq

// File: hdl/itr_host.sv
// itr_host: apb controlled host end; runs single bus cycles to the timer.
// assumes: apb master on mclk; count_hold wired to the timer's gate logic.
`timescale 1ns/100ps
module itr_host import itr_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// counter inhibit towards the timer
	output logic [NUM_CNT-1:0] count_hold,
	// timer bus
	itr_bus_if.host bus
);
	logic start_reg, cmd_write_reg, refused_reg, done_reg;
	logic [1:0] cmd_port_reg;
	logic [7:0] cmd_data_reg;
	logic seq_busy, seq_done;
	logic [7:0] seq_rdata;
	logic [1:0] acc_reg [NUM_CNT];
	logic rd_half_reg [NUM_CNT];
	logic wr_half_reg [NUM_CNT];
	logic latch_open_reg [NUM_CNT];
	logic setup, wr_cmd, busy, is_ctl, c_ok, bad;
	logic [1:0] c, cw_acc;
	logic [7:0] cdat;

	assign setup = psel && !penable;
	assign wr_cmd = psel && penable && pready && pwrite && paddr == REG_CMD;
	// an ending cycle still counts as busy, so its done flag is never lost
	assign busy = seq_busy || start_reg || seq_done;
	assign cdat = pwdata[CMD_DATA_LO +: 8];
	assign is_ctl = pwdata[CMD_PORT_LO +: 2] == PORT_CTRL;
	assign c = is_ctl ? cdat[CW_SEL_HI:CW_SEL_LO] : pwdata[CMD_PORT_LO +: 2];
	assign cw_acc = cdat[CW_ACC_HI:CW_ACC_LO];
	assign c_ok = c != PORT_CTRL;

	// an open sequence on the target blocks anything else to it
	always_comb begin
		bad = busy;
		if (!pwdata[CMD_WRITE] && is_ctl) begin
			bad = 1'b1; // [RULE_02]
		end else if (c_ok) begin
			if (rd_half_reg[c] || latch_open_reg[c]) begin
				bad = bad || pwdata[CMD_WRITE]; // [RULE_05] [RULE_10]
			end
			if (wr_half_reg[c]) begin
				bad = bad || is_ctl || !pwdata[CMD_WRITE]; // [RULE_11]
			end
		end
	end

	// apb slave, zero wait: answer in the first access cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup;
			pslverr <= setup && paddr != REG_CMD && paddr != REG_STATUS && paddr != REG_HOLD;
			prdata <= '0;
			if (setup && !pwrite && paddr == REG_STATUS) begin
				prdata[ST_BUSY] <= busy;
				prdata[ST_REFUSED] <= refused_reg;
				prdata[ST_DONE] <= done_reg;
				prdata[ST_DATA_LO +: 8] <= seq_rdata;
			end else if (setup && !pwrite && paddr == REG_HOLD) begin
				prdata[NUM_CNT-1:0] <= count_hold;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count_hold <= '0;
		end else if (psel && penable && pready && pwrite && paddr == REG_HOLD) begin
			count_hold <= pwdata[NUM_CNT-1:0]; // [RULE_03]
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			start_reg <= 1'b0;
			refused_reg <= 1'b0;
			done_reg <= 1'b0;
			cmd_write_reg <= 1'b0;
			cmd_port_reg <= '0;
			cmd_data_reg <= BYTE_ZERO;
		end else begin
			start_reg <= wr_cmd && !bad;
			if (wr_cmd) begin
				refused_reg <= bad;
				done_reg <= seq_done;
				cmd_write_reg <= pwdata[CMD_WRITE];
				cmd_port_reg <= pwdata[CMD_PORT_LO +: 2];
				cmd_data_reg <= cdat;
			end else if (seq_done) begin
				done_reg <= 1'b1;
			end
		end
	end

	// track each counter's byte sequence as the device will see it
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NUM_CNT; i++) begin
				acc_reg[i] <= ACC_RESET;
				rd_half_reg[i] <= 1'b0;
				wr_half_reg[i] <= 1'b0;
				latch_open_reg[i] <= 1'b0;
			end
		end else if (wr_cmd && !bad && c_ok) begin
			if (is_ctl && cw_acc == ACC_LATCH) begin
				latch_open_reg[c] <= 1'b1;
			end else if (is_ctl) begin
				acc_reg[c] <= cw_acc;
				rd_half_reg[c] <= 1'b0;
				wr_half_reg[c] <= 1'b0;
				latch_open_reg[c] <= 1'b0;
			end else if (pwdata[CMD_WRITE]) begin
				wr_half_reg[c] <= acc_reg[c] == ACC_BOTH && !wr_half_reg[c]; // [RULE_11]
			end else begin
				rd_half_reg[c] <= acc_reg[c] == ACC_BOTH && !rd_half_reg[c];
				if (acc_reg[c] != ACC_BOTH || rd_half_reg[c]) begin
					latch_open_reg[c] <= 1'b0; // [RULE_10]
				end
			end
		end
	end

	itr_bus_seq u_seq (
		.mclk(mclk),
		.rstn(rstn),
		.start(start_reg),
		.is_write(cmd_write_reg),
		.port(cmd_port_reg),
		.wdata(cmd_data_reg),
		.busy(seq_busy),
		.done(seq_done),
		.rdata(seq_rdata),
		.bus(bus)
	);
endmodule : itr_host

// File: hdl/itr_device.sv
// itr_device: three 16-bit down counters with count readback and snapshot.
// assumes: bus strobes and count clocks are synchronous to mclk;
// count clocks run well below mclk/2 so each rising edge is seen.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
// Contract
// [RULE_01] plain read returns counter chosen by port
// [RULE_02] control port is never read
// [RULE_03] host stops counter for stable plain read
// [RULE_04] low byte first, high byte second
// [RULE_05] finish both reads before writing count
// [RULE_06] control write with access 00 latches
// [RULE_07] latch copies count, counting continues
// [RULE_08] reads after latch return the snapshot
// [RULE_09] latch keeps mode, access and format
// [RULE_10] host reads all latched bytes first
// [RULE_11] count bytes loaded in programmed order
// [RULE_12] 16-bit down counter, binary or BCD
// [RULE_13] pointer returns low, snapshot freed after read
module itr_device import itr_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// per counter count clock and gate
	input wire logic [NUM_CNT-1:0] count_clk,
	input wire logic [NUM_CNT-1:0] gate,
	// host bus
	itr_bus_if.dev bus
);
	logic rd_n_q_reg;
	logic wr_n_q_reg;
	logic [1:0] port;
	logic rd_start, wr_start, ctl_hit, rd_active;
	logic [1:0] cw_sel;
	logic [1:0] cw_acc;
	logic [NUM_CNT-1:0] latch_pick;
	logic [NUM_CNT-1:0] ctl_pick;
	logic [NUM_CNT-1:0] load_pick;
	logic [NUM_CNT-1:0] read_pick;
	logic [7:0] rd_byte [NUM_CNT];

	// one-hot counter decode; select 3 hits nothing
	function automatic logic [NUM_CNT-1:0] pick(input logic [1:0] sel);
		pick = '0;
		if (sel != PORT_CTRL) begin
			pick[sel] = 1'b1;
		end
	endfunction : pick

	// four decade BCD decrement, 0000 wraps to 9999
	function automatic logic [15:0] bcd_dec(input logic [15:0] v);
		logic borrow;
		bcd_dec = v;
		borrow = 1'b1;
		for (int d = 0; d < 4; d++) begin
			if (borrow) begin
				if (v[4*d +: 4] == 4'h0) begin
					bcd_dec[4*d +: 4] = BCD_NINE;
				end else begin
					bcd_dec[4*d +: 4] = v[4*d +: 4] - 4'h1;
					borrow = 1'b0;
				end
			end
		end
	endfunction : bcd_dec

	assign port = {bus.port_select_high, bus.port_select_low};
	// a strobe acts once, on the cycle it is first seen low
	assign rd_start = !bus.cs_n && !bus.rd_n && rd_n_q_reg && port != PORT_CTRL; // [RULE_02]
	assign wr_start = !bus.cs_n && !bus.wr_n && wr_n_q_reg;
	assign rd_active = !bus.cs_n && !bus.rd_n && port != PORT_CTRL;
	assign ctl_hit = wr_start && port == PORT_CTRL;
	assign cw_sel = bus.data[CW_SEL_HI:CW_SEL_LO];
	assign cw_acc = bus.data[CW_ACC_HI:CW_ACC_LO];
	assign latch_pick = (ctl_hit && cw_acc == ACC_LATCH) ? pick(cw_sel) : '0; // [RULE_06]
	assign ctl_pick = (ctl_hit && cw_acc != ACC_LATCH) ? pick(cw_sel) : '0;
	assign load_pick = (wr_start && port != PORT_CTRL) ? pick(port) : '0;
	assign read_pick = rd_start ? pick(port) : '0; // [RULE_01]

	// last strobe levels, reset to idle so no false strobe follows reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rd_n_q_reg <= 1'b1;
			wr_n_q_reg <= 1'b1;
		end else begin
			rd_n_q_reg <= bus.rd_n;
			wr_n_q_reg <= bus.wr_n;
		end
	end

	// data is captured once per read strobe so the pointer step cannot tear it
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bus.dev_data_out <= BYTE_ZERO;
			bus.dev_data_oe_n <= 1'b1;
		end else begin
			if (rd_start) begin
				bus.dev_data_out <= rd_byte[port]; // [RULE_01] [RULE_04]
			end
			// the control port never drives the bus
			bus.dev_data_oe_n <= !rd_active; // [RULE_02]
		end
	end

	for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
		logic clk_q_reg;
		logic [15:0] count_reg;
		logic [15:0] snap_reg;
		logic [7:0] lo_hold_reg;
		logic [1:0] access_reg;
		logic bcd_reg;
		logic latched_reg;
		logic rd_hi_reg;
		logic wr_hi_reg;
		logic armed_reg;
		logic count_edge;
		logic load_done;
		logic rd_last;
		logic hi_sel;
		logic [15:0] src;
		logic [15:0] load_next;

		// count clock sampled on mclk; a pulse shorter than one mclk is lost
		assign count_edge = count_clk[i] && !clk_q_reg;
		assign load_done = load_pick[i] && (access_reg != ACC_BOTH || wr_hi_reg);
		assign rd_last = read_pick[i] && (access_reg != ACC_BOTH || rd_hi_reg);
		assign src = latched_reg ? snap_reg : count_reg; // [RULE_08]
		assign hi_sel = access_reg == ACC_HIGH || (access_reg == ACC_BOTH && rd_hi_reg);
		assign rd_byte[i] = hi_sel ? src[15:8] : src[7:0]; // [RULE_04]

		// one-byte loads leave the other byte at zero
		always_comb begin
			case (access_reg)
				ACC_LOW: load_next = {BYTE_ZERO, bus.data};
				ACC_HIGH: load_next = {bus.data, BYTE_ZERO};
				ACC_BOTH: load_next = {bus.data, lo_hold_reg};
				default: load_next = count_reg;
			endcase
		end

		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				clk_q_reg <= 1'b0;
			end else begin
				clk_q_reg <= count_clk[i];
			end
		end

		// only a full control word touches the settings, never a latch
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				access_reg <= ACC_RESET;
				bcd_reg <= 1'b0;
			end else if (ctl_pick[i]) begin
				access_reg <= cw_acc; // [RULE_09]
				bcd_reg <= bus.data[CW_BCD];
			end
		end

		// a new control word halts the counter until its count is loaded
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				count_reg <= COUNT_RESET;
				armed_reg <= 1'b0;
			end else if (load_done) begin
				count_reg <= load_next;
				armed_reg <= 1'b1;
			end else if (ctl_pick[i]) begin
				armed_reg <= 1'b0;
			end else if (count_edge && gate[i] && armed_reg) begin
				count_reg <= bcd_reg ? bcd_dec(count_reg) : count_reg - 16'h1; // [RULE_12]
			end
		end

		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				wr_hi_reg <= 1'b0;
				lo_hold_reg <= BYTE_ZERO;
			end else if (ctl_pick[i]) begin
				wr_hi_reg <= 1'b0;
			end else if (load_pick[i] && access_reg == ACC_BOTH) begin
				wr_hi_reg <= !wr_hi_reg;
				if (!wr_hi_reg) begin
					lo_hold_reg <= bus.data;
				end
			end
		end

		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				rd_hi_reg <= 1'b0;
			end else if (ctl_pick[i]) begin
				rd_hi_reg <= 1'b0;
			end else if (read_pick[i] && access_reg == ACC_BOTH) begin
				rd_hi_reg <= !rd_hi_reg; // [RULE_13]
			end
		end

		// a second latch before the first is read out is ignored
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				latched_reg <= 1'b0;
				snap_reg <= COUNT_RESET;
			end else if (ctl_pick[i]) begin
				latched_reg <= 1'b0;
			end else if (rd_last) begin
				latched_reg <= 1'b0; // [RULE_13]
			end else if (latch_pick[i] && !latched_reg) begin
				snap_reg <= count_reg; // [RULE_07]
				latched_reg <= 1'b1;
			end
		end
	end
endmodule : itr_device

// File: bench/itr_readback_props.sv
// itr_readback_props: drive and strobe timing checks on the timer bus.
// assumes: fed from the bus interface beside it, clocked by mclk.
`timescale 1ns/100ps
module itr_readback_props import itr_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// bus
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic port_select_high,
	input wire logic port_select_low,
	input wire logic host_data_oe_n,
	input wire logic dev_data_oe_n
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	logic ctl;
	assign ctl = ({port_select_high, port_select_low} == PORT_CTRL);
	property p_ctl_quiet;
		!cs_n && !rd_n && ctl |=> dev_data_oe_n;
	endproperty
	a_ctl_quiet: assert property (p_ctl_quiet)
		else $error("control port driven");
	property p_answer;
		$fell(rd_n) && !cs_n && !ctl |=> !dev_data_oe_n;
	endproperty
	a_answer: assert property (p_answer)
		else $error("no read answer");
	property p_drive;
		!dev_data_oe_n |-> !$past(rd_n) && !$past(cs_n);
	endproperty
	a_drive: assert property (p_drive)
		else $error("drive outside read");
	property p_clash;
		host_data_oe_n || dev_data_oe_n;
	endproperty
	a_clash: assert property (p_clash)
		else $error("both ends drive");
	property p_rd_width;
		$fell(rd_n) |-> (!rd_n)[*4] ##1 rd_n;
	endproperty
	a_rd_width: assert property (p_rd_width)
		else $error("read strobe width");
	property p_wr_width;
		$fell(wr_n) |-> (!cs_n throughout (!wr_n)[*4]) ##1 wr_n;
	endproperty
	a_wr_width: assert property (p_wr_width)
		else $error("write strobe width");
	property p_setup;
		$fell(rd_n) || $fell(wr_n) |-> !$past(cs_n, 2);
	endproperty
	a_setup: assert property (p_setup)
		else $error("select setup short");
	property p_recover;
		$rose(rd_n) || $rose(wr_n) |-> (rd_n && wr_n)[*5];
	endproperty
	a_recover: assert property (p_recover)
		else $error("recovery short");
	c_read: cover property ($fell(rd_n) && !ctl);
	c_ctl_write: cover property ($fell(wr_n) && ctl);
	c_count_write: cover property ($fell(wr_n) && !ctl);
endmodule : itr_readback_props

// File: bench/interval_timer_count_readback_tb.sv
// interval_timer_count_readback_tb: host and timer joined, driven over apb.
// assumes: bench pulses count clocks; gates follow count_hold only.
`timescale 1ns/100ps
module interval_timer_count_readback_tb import itr_pkg::*;;
	localparam int CYCLE_LIMIT = 30000;
	logic mclk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [APB_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [NUM_CNT-1:0] count_hold, count_clk, gate;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	itr_bus_if itr_bus_if_inst ();
	itr_host itr_host_inst (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .count_hold(count_hold), .bus(itr_bus_if_inst));
	itr_device itr_device_inst (.mclk(mclk), .rstn(rstn), .count_clk(count_clk),
		.gate(gate), .bus(itr_bus_if_inst));
	itr_readback_props itr_readback_props_inst (.mclk(mclk), .rstn(rstn),
		.cs_n(itr_bus_if_inst.cs_n), .rd_n(itr_bus_if_inst.rd_n),
		.wr_n(itr_bus_if_inst.wr_n), .port_select_high(itr_bus_if_inst.port_select_high),
		.port_select_low(itr_bus_if_inst.port_select_low),
		.host_data_oe_n(itr_bus_if_inst.host_data_oe_n),
		.dev_data_oe_n(itr_bus_if_inst.dev_data_oe_n));
	// stopping a counter is the host's job, so gates follow its hold bits
	assign gate = ~count_hold;
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	always @(posedge mclk) begin
		cycles++;
		if (cycles == CYCLE_LIMIT) begin
			miscompares++;
			$display("CHECK FAILED at %0t: timeout", $time);
			summarize();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	// entered just after a rising edge; leaves one idle edge so psel is set once a step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) begin
			@(posedge mclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb
	task automatic do_cmd(input logic w, input logic [1:0] p, input logic [7:0] d,
		output logic [31:0] st);
		logic e;
		apb(1'b1, REG_CMD, {16'h0000, d, 5'h00, p, w}, st, e);
		st = '0;
		while (st[ST_DONE] !== 1'b1 && st[ST_REFUSED] !== 1'b1) begin
			apb(1'b0, REG_STATUS, 32'h0000_0000, st, e);
		end
	endtask : do_cmd
	task automatic put(input logic [1:0] p, input logic [7:0] d);
		logic [31:0] st;
		do_cmd(1'b1, p, d, st);
	endtask : put
	task automatic get(input logic [1:0] p, output logic [7:0] b);
		logic [31:0] st;
		do_cmd(1'b0, p, 8'h00, st);
		b = st[15:8];
	endtask : get
	task automatic get16(input logic [1:0] p, output logic [15:0] v);
		get(p, v[7:0]);
		get(p, v[15:8]);
	endtask : get16
	// exactly n count edges reach counter i, all others stay stopped
	task automatic count(input int i, input int n);
		logic [31:0] r;
		logic e;
		apb(1'b1, REG_HOLD, 32'(3'h7 & ~(3'h1 << i)), r, e);
		repeat (n) begin
			count_clk[i] <= 1'b1;
			repeat (2) @(posedge mclk);
			count_clk[i] <= 1'b0;
			repeat (2) @(posedge mclk);
		end
		apb(1'b1, REG_HOLD, 32'h0000_0007, r, e);
	endtask : count
	function automatic logic [15:0] dec(input logic [15:0] v, input int n, input logic bcd);
		logic [15:0] r;
		r = v;
		repeat (n) begin
			if (!bcd) begin
				r = r - 16'h0001;
			end else begin
				for (int d = 0; d < 16; d += 4) begin
					if (r[d +: 4] != 4'h0) begin
						r[d +: 4] = r[d +: 4] - 4'h1;
						break;
					end
					r[d +: 4] = BCD_NINE;
				end
			end
		end
		return r;
	endfunction : dec
	initial begin
		logic [31:0] r;
		logic e;
		logic [15:0] v, got;
		logic [7:0] b, g;
		logic [1:0] p;
		int n;
		itr_access_type acc;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		count_clk = '0;
		rstn = 1'b0;
		void'($urandom(32'h82c473a1));
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		apb(1'b1, REG_HOLD, 32'h0000_0007, r, e);
		apb(1'b0, REG_HOLD, 32'h0000_0000, r, e);
		chk(r[15:0], 16'h0007, "hold");
		apb(1'b0, 12'h00c, 32'h0000_0000, r, e);
		chk(16'(e), 16'h0001, "unmapped");
		for (int i = 0; i < NUM_CNT; i++) begin
			p = 2'(i);
			v = 16'($urandom());
			n = 1 + $urandom_range(19);
			put(PORT_CTRL, {p, ACC_BOTH, 4'h0});
			put(p, v[7:0]);
			put(p, v[15:8]);
			get16(p, got);
			chk(got, v, "plain");
			put(PORT_CTRL, {p, ACC_LATCH, 4'($urandom())});
			count(i, n);
			put(PORT_CTRL, {p, ACC_LATCH, 4'h0});
			count(i, 3);
			get16(p, got);
			chk(got, v, "snapshot");
			get16(p, got);
			chk(got, dec(v, n + 3, 1'b0), "live");
		end
		for (int k = 0; k < 4; k++) begin
			v = (k < 2) ? 16'h0000 : 16'h0100;
			put(PORT_CTRL, {2'h2, ACC_BOTH, 3'h0, k[0]});
			put(2'h2, v[7:0]);
			put(2'h2, v[15:8]);
			count(2, 2);
			get16(2'h2, got);
			chk(got, dec(v, 2, k[0]), "wrap");
		end
		for (int k = 0; k < 2; k++) begin
			acc = k ? ACC_HIGH : ACC_LOW;
			b = 8'h80 | 8'($urandom_range(127));
			n = 1 + $urandom_range(19);
			put(PORT_CTRL, {2'h1, acc, 4'h0});
			put(2'h1, b);
			get(2'h1, g);
			chk(16'(g), 16'(b), "one byte");
			put(PORT_CTRL, {2'h1, ACC_LATCH, 4'h0});
			count(1, n);
			get(2'h1, g);
			chk(16'(g), 16'(b), "one byte snapshot");
			if (acc == ACC_LOW) begin
				get(2'h1, g);
				chk(16'(g), 16'(b - 8'(n)), "one byte live");
			end
		end
		do_cmd(1'b0, PORT_CTRL, 8'h00, r);
		chk(16'(r[ST_REFUSED]), 16'h0001, "ctl read");
		put(PORT_CTRL, {2'h0, ACC_BOTH, 4'h0});
		put(2'h0, 8'h34);
		put(2'h0, 8'h12);
		get(2'h0, g);
		do_cmd(1'b1, 2'h0, 8'h55, r);
		chk(16'(r[ST_REFUSED]), 16'h0001, "load mid read");
		get(2'h0, g);
		chk(16'(g), 16'h0012, "msb");
		put(PORT_CTRL, {2'h0, ACC_LATCH, 4'h0});
		do_cmd(1'b1, 2'h0, 8'h55, r);
		chk(16'(r[ST_REFUSED]), 16'h0001, "load on latch");
		get16(2'h0, got);
		chk(got, 16'h1234, "latched");
		put(PORT_CTRL, {2'h3, ACC_LOW, 4'h0});
		get16(2'h0, got);
		chk(got, 16'h1234, "select 3 ignored");
		summarize();
	end
endmodule : interval_timer_count_readback_tb
